/* stepper_cfg_pkg.sv */
package stepper_cfg_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte-wide registers)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CCW_PW_LO  = 8'h18;
   localparam logic [7:0] OFS_CCW_PW_HI  = 8'h19;
   localparam logic [7:0] OFS_CW_SC_LO   = 8'h1a;
   localparam logic [7:0] OFS_CW_SC_HI   = 8'h1b;
   localparam logic [7:0] OFS_CCW_SC_LO  = 8'h1c;
   localparam logic [7:0] OFS_CCW_SC_HI  = 8'h1d;
   localparam logic [7:0] OFS_CW_RC_LO   = 8'h1e;
   localparam logic [7:0] OFS_CW_RC_HI   = 8'h1f;
   localparam logic [7:0] OFS_CCW_RC_LO  = 8'h20;
   localparam logic [7:0] OFS_CCW_RC_HI  = 8'h21;
   localparam logic [7:0] OFS_OVR_IRQ0   = 8'h22;
   localparam logic [7:0] OFS_OVR_IRQ1   = 8'h23;
   localparam logic [7:0] OFS_RAMP_CTRL  = 8'h24;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [5:0] RST_RAMP_CTRL  = 6'h00;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int PW_RANGE_HI    = 15;  // Range selector top bit
   localparam int PW_RANGE_LO    = 13;  // Range selector bottom bit
   localparam int PW_MANT_W      = 13;  // Mantissa width
   localparam int RAMP_UP_BIT    = 5;   // Accelerate on start
   localparam int RAMP_DOWN_BIT  = 4;   // Decelerate on stop
   localparam int RAMP_FACT_W    = 4;   // Ramp factor field width
   localparam int ACT_ENABLE_BIT = 0;   // Interrupt motor control on
   localparam int ACT_UNIT_BIT   = 4;   // Extra count in rotations

   localparam logic [3:0] RAMP_FACT_MAX = 4'hd;  // Highest legal code

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int SYS_CLK_HZ     = 50_000_000;
   localparam int BASE_CLK_HZ    = 1_000_000;  // Nominal time base
   localparam int TICK_DIV       = SYS_CLK_HZ / BASE_CLK_HZ;
   localparam int MIN_STEP_US    = 3;          // Smallest pulse step
   localparam int MIN_STEP_TICKS = MIN_STEP_US * BASE_CLK_HZ / 1_000_000;
   localparam int MAX_UNITS      = 8192;       // Mantissa + 1 at top

   // Motion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RAMP_UP,
      ST_CRUISE,
      ST_RAMP_DOWN
   } motion_state_t;

endpackage

/* stepper_count_ramp_config.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1: Pulse width: bits 15-13 range, 12-0 mantissa
// RULE2: Minimum step is 3 us times 2^D
// RULE3: All ranges timed from 1 MHz base
// RULE4: Final width is minimum step times mantissa+1
// RULE5: Ramps start and end at range maximum
// RULE6: CCW pulse width at 18h/19h, reset zero
// RULE7: CW step count at 1Ah/1Bh, reset zero
// RULE8: CCW step count at 1Ch/1Dh, reset zero
// RULE9: CW rotation count at 1Eh/1Fh, reset zero
// RULE10: CCW rotation count at 20h/21h, reset zero
// RULE11: Extra count ignored unless both enables set
// RULE12: Interrupt overdrives by extra count, same direction
// RULE13: Zero extra count means no extra motion
// RULE14: Setup bit 4 selects steps or rotations
// RULE15: Ramp control bits 5 up, 4 down
// RULE16: Ramp factor code D multiplies by 2^D
// RULE17: Ramp step is minimum step times factor
// RULE18: Ramp-up shrinks width down to programmed width
// RULE19: Ramp-down grows width up to range maximum
// RULE20: CW pulse width at 16h/17h, same encoding
// RULE21: Software loads nonzero steps-per-rev before rotations
// RULE22: Parameters are unsigned, low byte at even address
module stepper_count_ramp_config
   import stepper_cfg_pkg::*;
#(
   parameter int TICK_DIV_P = TICK_DIV   // System clocks per 1 us tick
)(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_we,
   output logic      [7:0]  reg_rdata,
   // Settings held elsewhere in the device
   input  wire logic [15:0] cw_pulse_width,
   input  wire logic [15:0] steps_per_rev,
   input  wire logic [7:0]  interrupt_action_setup,
   input  wire logic [1:0]  interrupt_overrun_enable,
   // Motion commands and interrupt events
   input  wire logic        motion_start,
   input  wire logic        motion_ccw,
   input  wire logic        motion_stop,
   input  wire logic        pin0_interrupt,
   input  wire logic        pin1_interrupt,
   // Motion outputs
   output logic             step_pulse,
   output logic             motion_busy,
   output logic             motion_dir_ccw,
   output logic [13:0]      step_width_units
);

   // Divider must fit its 8-bit counter and leave a gap between ticks
   if (TICK_DIV_P < 2 || TICK_DIV_P > 255) begin : g_bad_div
      $error("TICK_DIV_P out of range");
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0] ccw_pw;        // CCW pulse width
   logic [15:0] cw_steps;      // CW step count
   logic [15:0] ccw_steps;     // CCW step count
   logic [15:0] cw_rots;       // CW rotation count
   logic [15:0] ccw_rots;      // CCW rotation count
   logic [7:0]  ovr_cnt [2];   // Extra counts per interrupt
   logic [5:0]  ramp_ctrl;     // Ramp enables and factor

   // Byte write into a 16-bit pair: even address is the low byte [RULE22]
   function automatic logic [15:0] pair_wr(input logic [15:0] cur,
                                           input logic [7:0]  lo_ofs,
                                           input logic [7:0]  a,
                                           input logic [7:0]  d);
      logic [15:0] r;
      r = cur;
      if (a == lo_ofs)
         r[7:0] = d;
      else if (a == lo_ofs + 8'h01)
         r[15:8] = d;
      return r;
   endfunction

   // Write decode
   wire [15:0] next_ccw_pw    = pair_wr(ccw_pw, OFS_CCW_PW_LO,
                                        reg_addr, reg_wdata); // [RULE6]
   wire [15:0] next_cw_steps  = pair_wr(cw_steps, OFS_CW_SC_LO,
                                        reg_addr, reg_wdata); // [RULE7]
   wire [15:0] next_ccw_steps = pair_wr(ccw_steps, OFS_CCW_SC_LO,
                                        reg_addr, reg_wdata); // [RULE8]
   wire [15:0] next_cw_rots   = pair_wr(cw_rots, OFS_CW_RC_LO,
                                        reg_addr, reg_wdata); // [RULE9]
   wire [15:0] next_ccw_rots  = pair_wr(ccw_rots, OFS_CCW_RC_LO,
                                        reg_addr, reg_wdata); // [RULE10]

   // Register writes, all fields clear on reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ccw_pw    <= {RST_BYTE, RST_BYTE};
         cw_steps  <= {RST_BYTE, RST_BYTE};
         ccw_steps <= {RST_BYTE, RST_BYTE};
         cw_rots   <= {RST_BYTE, RST_BYTE};
         ccw_rots  <= {RST_BYTE, RST_BYTE};
         ovr_cnt   <= '{RST_BYTE, RST_BYTE};
         ramp_ctrl <= RST_RAMP_CTRL;                   // [RULE15]
      end else if (reg_we) begin
         ccw_pw    <= next_ccw_pw;
         cw_steps  <= next_cw_steps;
         ccw_steps <= next_ccw_steps;
         cw_rots   <= next_cw_rots;
         ccw_rots  <= next_ccw_rots;
         if (reg_addr == OFS_OVR_IRQ0)
            ovr_cnt[0] <= reg_wdata;
         if (reg_addr == OFS_OVR_IRQ1)
            ovr_cnt[1] <= reg_wdata;
         if (reg_addr == OFS_RAMP_CTRL)
            ramp_ctrl <= reg_wdata[5:0];               // Bits 7:6 read 0
      end
   end

   // Read mux; unmapped offsets read as zero
   logic [7:0] next_rdata;
   always_comb begin
      case (reg_addr)
         OFS_CCW_PW_LO: next_rdata = ccw_pw[7:0];
         OFS_CCW_PW_HI: next_rdata = ccw_pw[15:8];
         OFS_CW_SC_LO:  next_rdata = cw_steps[7:0];
         OFS_CW_SC_HI:  next_rdata = cw_steps[15:8];
         OFS_CCW_SC_LO: next_rdata = ccw_steps[7:0];
         OFS_CCW_SC_HI: next_rdata = ccw_steps[15:8];
         OFS_CW_RC_LO:  next_rdata = cw_rots[7:0];
         OFS_CW_RC_HI:  next_rdata = cw_rots[15:8];
         OFS_CCW_RC_LO: next_rdata = ccw_rots[7:0];
         OFS_CCW_RC_HI: next_rdata = ccw_rots[15:8];
         OFS_OVR_IRQ0:  next_rdata = ovr_cnt[0];
         OFS_OVR_IRQ1:  next_rdata = ovr_cnt[1];
         OFS_RAMP_CTRL: next_rdata = {2'b00, ramp_ctrl};
         default:       next_rdata = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge sys_clk) begin
      if (srst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   // ----------------------------------------------------------------
   // Pulse-width decode for the active direction
   // ----------------------------------------------------------------
   logic          dir_ccw;       // Direction of the running move
   motion_state_t state;         // Sequencer state

   wire [15:0] act_pw   = dir_ccw ? ccw_pw : cw_pulse_width; // [RULE20]
   wire [2:0]  range_d  = act_pw[PW_RANGE_HI:PW_RANGE_LO];   // [RULE1]
   wire [12:0] mantissa = act_pw[PW_MANT_W-1:0];             // [RULE1]
   // Programmed width in minimum-step units
   wire [13:0] target_units = {1'b0, mantissa} + 14'd1;      // [RULE4]
   // Base ticks per minimum step: 3 shifted by the range
   wire [9:0]  unit_ticks = 10'(MIN_STEP_TICKS) << range_d;  // [RULE2]

   // Ramp increment in units: 2^factor, reserved codes clamp
   wire [3:0]  fact_code = (ramp_ctrl[3:0] > RAMP_FACT_MAX) ?
                           RAMP_FACT_MAX : ramp_ctrl[3:0];
   wire [14:0] ramp_inc  = 15'd1 << fact_code;               // [RULE16]

   // ----------------------------------------------------------------
   // 1 MHz base tick from the system clock
   // ----------------------------------------------------------------
   logic [7:0] tick_cnt;   // System clock divider
   logic       tick_en;    // One cycle per microsecond

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tick_cnt <= 8'h00;
         tick_en  <= 1'b0;
      end else if (tick_cnt == 8'(TICK_DIV_P - 1)) begin
         tick_cnt <= 8'h00;
         tick_en  <= 1'b1;                                   // [RULE3]
      end else begin
         tick_cnt <= tick_cnt + 8'h01;
         tick_en  <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Step timing: ticks make units, units make a step
   // ----------------------------------------------------------------
   logic [9:0]  unit_cnt;    // Ticks within one minimum step
   logic [13:0] width_cnt;   // Units within one step
   logic [13:0] cur_units;   // Present step width in units
   logic [32:0] remaining;   // Steps still to run

   wire running   = (state != ST_IDLE);
   wire unit_done = running && tick_en && (unit_cnt >= unit_ticks - 10'd1);
   wire step_done = unit_done && (width_cnt >= cur_units - 14'd1);

   // Step timing counters
   always_ff @(posedge sys_clk) begin
      if (srst || !running) begin
         unit_cnt  <= 10'h000;
         width_cnt <= 14'h0000;
      end else if (unit_done) begin
         unit_cnt  <= 10'h000;
         width_cnt <= step_done ? 14'h0000 : width_cnt + 14'h0001;
      end else if (tick_en) begin
         unit_cnt  <= unit_cnt + 10'h001;
      end
   end

   // ----------------------------------------------------------------
   // Move length and extra-count decode
   // ----------------------------------------------------------------
   wire [15:0] sel_steps = motion_ccw ? ccw_steps : cw_steps;
   wire [15:0] sel_rots  = motion_ccw ? ccw_rots : cw_rots;
   // Rotations need steps-per-rev loaded by software
   wire [31:0] rot_steps = sel_rots * steps_per_rev;         // [RULE21]
   wire [32:0] move_len  = {17'h00000, sel_steps} + {1'b0, rot_steps};

   // Interrupt acceptance; both enables must be on
   wire act_on  = interrupt_action_setup[ACT_ENABLE_BIT];
   wire irq0_ok = pin0_interrupt && act_on
                  && interrupt_overrun_enable[0]
                  && (ovr_cnt[0] != 8'h00);          // [RULE11] [RULE13]
   wire irq1_ok = pin1_interrupt && act_on
                  && interrupt_overrun_enable[1]
                  && (ovr_cnt[1] != 8'h00);          // [RULE11] [RULE13]
   wire [7:0]  extra_raw = irq0_ok ? ovr_cnt[0] : ovr_cnt[1];
   wire [31:0] extra_rot = {24'h000000, extra_raw} * {16'h0000, steps_per_rev};
   wire [32:0] extra_len = interrupt_action_setup[ACT_UNIT_BIT] ?
                           {1'b0, extra_rot} :
                           {25'h0000000, extra_raw};         // [RULE14]
   wire extra_hit = running && (irq0_ok || irq1_ok);

   // Ramp width arithmetic with clamping
   wire [14:0] dn_width = {1'b0, cur_units} - ramp_inc;
   wire [14:0] up_width = {1'b0, cur_units} + ramp_inc;
   wire dn_reach = (ramp_inc >= {1'b0, cur_units})
                   || (dn_width <= {1'b0, target_units});
   wire up_reach = (up_width >= 15'(MAX_UNITS));
   wire last_step = (remaining <= 33'd1);
   wire ramp_dn_en = ramp_ctrl[RAMP_DOWN_BIT];
   wire ramp_up_en = ramp_ctrl[RAMP_UP_BIT];

   // ----------------------------------------------------------------
   // Motion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state     <= ST_IDLE;
         dir_ccw   <= 1'b0;
         cur_units <= 14'(MAX_UNITS);
         remaining <= 33'h0;
      end else begin
         case (state)
            // Wait for a start with a non-empty move
            ST_IDLE: begin
               if (motion_start && move_len != 33'h0) begin
                  dir_ccw   <= motion_ccw;
                  remaining <= move_len;
                  if (ramp_up_en) begin
                     cur_units <= 14'(MAX_UNITS);            // [RULE5]
                     state     <= ST_RAMP_UP;                // [RULE15]
                  end else begin
                     cur_units <= 14'(MAX_UNITS);
                     state     <= ST_CRUISE;
                  end
               end
            end
            // Accelerate toward, then run at, the programmed width
            ST_RAMP_UP, ST_CRUISE: begin
               if (state == ST_CRUISE)
                  cur_units <= target_units;                 // [RULE4]
               if (motion_stop) begin
                  state <= ramp_dn_en ? ST_RAMP_DOWN : ST_IDLE;
               end else if (extra_hit) begin
                  remaining <= extra_len;                    // [RULE12]
               end else if (step_done) begin
                  remaining <= remaining - 33'd1;
                  if (state == ST_RAMP_UP) begin
                     if (dn_reach) begin
                        cur_units <= target_units;           // [RULE18]
                        state     <= ST_CRUISE;
                     end else begin
                        cur_units <= dn_width[13:0];         // [RULE17]
                     end
                  end
                  if (last_step)
                     state <= ramp_dn_en ? ST_RAMP_DOWN : ST_IDLE;
               end
            end
            // Decelerate up to the range maximum, then stop
            ST_RAMP_DOWN: begin
               if (step_done) begin
                  if (up_reach) begin
                     cur_units <= 14'(MAX_UNITS);            // [RULE5]
                     state     <= ST_IDLE;
                  end else begin
                     cur_units <= up_width[13:0];            // [RULE19]
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Registered motion outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         step_pulse       <= 1'b0;
         motion_busy      <= 1'b0;
         motion_dir_ccw   <= 1'b0;
         step_width_units <= 14'h0000;
      end else begin
         step_pulse       <= step_done;
         motion_busy      <= running;
         motion_dir_ccw   <= dir_ccw;
         step_width_units <= cur_units;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (srst)
      tick_en |=> !tick_en [*1])                             // [RULE3]
      else $error("base tick not spaced");

   a_unit_length: assert property (@(posedge sys_clk) disable iff (srst)
      unit_ticks == (10'd3 << range_d))                      // [RULE2]
      else $error("minimum step length wrong");

   a_field_split: assert property (@(posedge sys_clk) disable iff (srst)
      target_units == {1'b0, act_pw[12:0]} + 14'd1)          // [RULE1]
      else $error("mantissa split wrong");

   a_ramp_start: assert property (@(posedge sys_clk) disable iff (srst)
      (state == ST_IDLE && motion_start && move_len != 33'h0
       && ramp_up_en) |=> (state == ST_RAMP_UP
       && cur_units == 14'(MAX_UNITS)))                      // [RULE5]
      else $error("ramp-up not at range maximum");

   a_ramp_floor: assert property (@(posedge sys_clk) disable iff (srst)
      (state == ST_RAMP_UP) |-> (cur_units >= target_units)) // [RULE18]
      else $error("ramp-up passed programmed width");

   a_ramp_step: assert property (@(posedge sys_clk) disable iff (srst)
      (state == ST_RAMP_UP && step_done && !motion_stop && !extra_hit
       && !dn_reach && !last_step)
      |=> cur_units == $past(cur_units) - $past(ramp_inc[13:0])) // [RULE17]
      else $error("ramp step size wrong");

   a_down_ceiling: assert property (@(posedge sys_clk) disable iff (srst)
      (state == ST_RAMP_DOWN && step_done && up_reach)
      |=> (state == ST_IDLE && cur_units == 14'(MAX_UNITS))) // [RULE19]
      else $error("ramp-down end wrong");

   a_extra_ignored: assert property (@(posedge sys_clk) disable iff (srst)
      (running && pin0_interrupt && !pin1_interrupt && !act_on)
      |-> !extra_hit)                                        // [RULE11]
      else $error("extra count taken while disabled");

   a_extra_zero: assert property (@(posedge sys_clk) disable iff (srst)
      (pin0_interrupt && ovr_cnt[0] == 8'h00 && !pin1_interrupt)
      |-> !extra_hit)                                        // [RULE13]
      else $error("zero extra count caused motion");

   a_extra_load: assert property (@(posedge sys_clk) disable iff (srst)
      (extra_hit && !motion_stop && state != ST_RAMP_DOWN)
      |=> (remaining == $past(extra_len)
           && dir_ccw == $past(dir_ccw)))                    // [RULE12]
      else $error("extra count not loaded");

   a_extra_units: assert property (@(posedge sys_clk) disable iff (srst)
      (irq0_ok && interrupt_action_setup[ACT_UNIT_BIT] == 1'b0)
      |-> extra_len == {25'h0000000, ovr_cnt[0]})            // [RULE14]
      else $error("extra steps misread");

   a_reg_reset: assert property (@(posedge sys_clk)
      srst |=> (ccw_pw == 16'h0000 && cw_steps == 16'h0000
       && ramp_ctrl == 6'h00))                        // [RULE6] [RULE15]
      else $error("register not cleared by reset");

   a_pair_write: assert property (@(posedge sys_clk) disable iff (srst)
      (reg_we && reg_addr == OFS_CW_SC_HI)
      |=> cw_steps == {$past(reg_wdata), $past(cw_steps[7:0])}) // [RULE22]
      else $error("high byte write wrong");

endmodule

/* stepper_count_ramp_config_bench.sv */
`timescale 1ns/1ps
module stepper_count_ramp_config_bench;
   import stepper_cfg_pkg::*;
   localparam int TD = 2;          // Shortened tick divider
   logic        sys_clk = 1'b0;
   logic        srst    = 1'b1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic        reg_we;
   logic [15:0] cw_pw   = 16'h0003; // Clockwise pulse width
   logic [15:0] spr;
   logic [7:0]  act     = 8'h01;    // Interrupt motor control on
   logic [1:0]  ovr_en  = 2'b01;    // Extra count on pin0 only
   logic        start   = 1'b0;
   logic        ccw     = 1'b0;
   logic        irq0    = 1'b0;
   logic        irq1    = 1'b0;
   logic        stop    = 1'b0;
   logic        step_pulse, motion_busy, motion_dir_ccw;
   logic [13:0] step_width_units;
   logic [7:0]  wd [8'h18:8'h24];   // Bytes written per offset
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n, np, per, last;

   always #10 sys_clk = ~sys_clk;

   stepper_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
      .steps_per_rev(spr));

   stepper_count_ramp_config #(.TICK_DIV_P(TD)) i_dut (
      .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
      .cw_pulse_width(cw_pw), .steps_per_rev(spr),
      .interrupt_action_setup(act), .interrupt_overrun_enable(ovr_en),
      .motion_start(start), .motion_ccw(ccw), .motion_stop(stop),
      .pin0_interrupt(irq0), .pin1_interrupt(irq1),
      .step_pulse(step_pulse), .motion_busy(motion_busy),
      .motion_dir_ccw(motion_dir_ccw),
      .step_width_units(step_width_units));

   // Expected read-back: ramp control top bits read zero
   function automatic logic [7:0] exp_rb(int a, logic [7:0] v);
      return (a == 8'h24) ? (v & 8'h3f) : v;
   endfunction
   // Expected clocks per step at the programmed width
   function automatic int exp_per(logic [15:0] pw);
      return (pw[12:0] + 1) * MIN_STEP_US * (1 << pw[15:13]) * TD;
   endfunction

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %0t out got %h exp %h", $time, got, exp);
      end
   endtask
   // Start pulse with direction
   task automatic go(input logic dir);
      @(posedge sys_clk);
      start <= 1'b1;
      ccw   <= dir;
      @(posedge sys_clk);
      start <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge sys_clk);
      n_mismatch++;
      wrap_up();
   end

   // Main sequence
   initial begin
      void'($urandom(32'h37fe18b0));
      repeat (16) @(posedge sys_clk);
      srst  <= 1'b0;
      cw_pw <= {3'h0, 10'h000, 3'($urandom_range(1, 7))};
      for (int a = 8'h18; a <= 8'h24; a++) begin
         i_host.rd(8'(a), d);
         chk_reg(d, 8'h00);
      end
      for (int a = 8'h18; a <= 8'h24; a++) begin
         wd[a] = 8'($urandom);
         i_host.wr(8'(a), wd[a]);
      end
      i_host.wr(8'h30, 8'h5a);
      for (int a = 8'h18; a <= 8'h24; a++) begin
         i_host.rd(8'(a), d);
         chk_reg(d, exp_rb(a, wd[a]));
      end
      i_host.rd(8'h30, d);
      chk_reg(d, 8'h00);
      // Three clockwise steps, ramp-up by factor 2^12, no ramp-down
      i_host.wr(8'h1a, 8'h03);
      for (int a = 8'h1b; a <= 8'h21; a++) i_host.wr(8'(a), 8'h00);
      i_host.wr(8'h22, 8'h03);
      i_host.wr(8'h23, 8'h07);
      i_host.wr(8'h24, 8'h2c);
      go(1'b1);
      repeat (3) @(posedge sys_clk);
      #1;
      chk_out(16'(motion_busy), 16'h0000);
      go(1'b0);
      repeat (3) @(posedge sys_clk);
      #1;
      chk_out(16'(motion_busy), 16'h0001);
      chk_out(16'(step_width_units), 16'h2000);
      // Two ramp-up steps: 8192 units, then 4096 units
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge sys_clk);
            #1;
            n++;
         end while (step_pulse !== 1'b1 && n < 60000);
         if (step_pulse !== 1'b1) n_mismatch++;
      end
      chk_out(16'(step_width_units), 16'h1000);
      @(posedge sys_clk);
      irq1 <= 1'b1;
      @(posedge sys_clk);
      irq1 <= 1'b0;
      irq0 <= 1'b1;
      @(posedge sys_clk);
      irq0 <= 1'b0;
      #1;
      chk_out(16'(step_width_units), 16'(cw_pw[12:0] + 1));
      np = 0;
      n = 0;
      last = 0;
      per = 0;
      while (motion_busy === 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (step_pulse === 1'b1) begin
            np++;
            per = n - last;
            last = n;
         end
      end
      if (motion_busy !== 1'b0) n_mismatch++;
      chk_out(16'(np), 16'h0003);
      chk_out(16'(per >= exp_per(cw_pw) - TD && per <= exp_per(cw_pw) + TD),
              16'h0001);
      chk_out(16'(motion_dir_ccw), 16'h0000);
      // CCW move from one rotation; stop mid-run ramps down to maximum
      i_host.wr(8'h18, 8'h04);
      i_host.wr(8'h19, 8'h00);
      i_host.wr(8'h20, 8'h01);
      i_host.wr(8'h24, 8'h1d);
      go(1'b1);
      np = 0;
      n = 0;
      while (np < 3 && n < 2000) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (step_pulse === 1'b1) np++;
      end
      chk_out(16'(step_width_units), 16'h0005);
      chk_out(16'(motion_dir_ccw), 16'h0001);
      @(posedge sys_clk);
      stop <= 1'b1;
      @(posedge sys_clk);
      stop <= 1'b0;
      np = 0;
      while (motion_busy === 1'b1 && n < 4000) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (step_pulse === 1'b1) np++;
      end
      if (motion_busy !== 1'b0) n_mismatch++;
      chk_out(16'(np), 16'h0001);
      chk_out(16'(step_width_units), 16'h2000);
      wrap_up();
   end
endmodule

/* stepper_host_model.sv */
`timescale 1ns/1ps
// Host side: byte writes and reads on the register port
module stepper_host_model (
   // Clock
   input  wire logic        sys_clk,
   // Register port
   output logic      [7:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_we,
   input  wire logic [7:0]  reg_rdata,
   // Settings kept by the host
   output logic      [15:0] steps_per_rev
);
   // Idle values at time zero
   initial begin
      reg_addr      = 8'h00;
      reg_wdata     = 8'h00;
      reg_we        = 1'b0;
      steps_per_rev = 16'h00c8; // Nonzero before any rotation move
   end

   // One byte write, strobe high for one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge sys_clk);
      reg_we    <= 1'b0;
      reg_wdata <= ~d; // Released bus no longer shows the byte
   endtask

   // One byte read, data registered one cycle late
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      @(posedge sys_clk);
      #1;
      d = reg_rdata;
   endtask
endmodule
